// ===== logic/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // Opcodes.
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  localparam logic [7:0] OP_UID_READ = 8'h4B;
  localparam logic [7:0] OP_TABLE_READ = 8'h5A;
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;

  // Frame layout, in bytes and bits of the serial link.
  localparam int UID_DUMMY_BYTES = 4;
  localparam int UID_BITS = 128;
  localparam int TABLE_ADDR_BYTES = 3;
  localparam int TABLE_DUMMY_BYTES = 1;
  localparam int OPCODE_BITS = 8;

  // Header area contents.
  localparam logic [7:0] SIG_BYTE0 = 8'h53;
  localparam logic [7:0] SIG_BYTE1 = 8'h46;
  localparam logic [7:0] SIG_BYTE2 = 8'h44;
  localparam logic [7:0] SIG_BYTE3 = 8'h50;
  localparam logic [7:0] REV_MINOR = 8'h00;
  localparam logic [7:0] REV_MAJOR = 8'h01;
  localparam logic [7:0] HEADER_COUNT = 8'h01;
  localparam logic [7:0] UNUSED_BYTE = 8'hFF;
  localparam logic [7:0] HDR0_ID = 8'h00;
  localparam logic [7:0] HDR0_LENGTH = 8'h09;
  localparam logic [23:0] HDR0_POINTER = 24'h000030;
  localparam logic [7:0] HDR1_LENGTH = 8'h03;
  localparam logic [23:0] HDR1_POINTER = 24'h000060;
  localparam logic [7:0] TABLE_REV_MINOR = 8'h00;
  localparam logic [7:0] TABLE_REV_MAJOR = 8'h01;

  // Reset values.
  // Pin idle levels, ordered as the link struct: deselected, clock low, data low.
  localparam logic [2:0] SYNC_RESET = 3'h4;
  localparam logic [8:0] COUNT_RESET = 9'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef struct packed {
    logic selN;
    logic clk;
    logic din;
  } link_in_s;

  typedef struct packed {
    logic resetPulse;
    logic abortOp;
  } reset_evt_s;

endpackage : flash_cmd_pkg

// ===== logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Pins.
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // Each bit resets to its pin's idle level, so no false edge follows reset.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
    end
  end

  assign pinOut = stage2_r;
endmodule : pin_sync

// ===== logic/header_rom.sv
`timescale 1ns/1ps
module header_rom #(
  parameter logic [7:0] MAKER_ID = 8'hA5
) (
  // Lookup.
  input wire logic [7:0] addr,
  output logic [7:0] data
);
  // Bytes past the header area read as unused.
  always_comb begin
    case (addr)
      8'h00: data = flash_cmd_pkg::SIG_BYTE0;
      8'h01: data = flash_cmd_pkg::SIG_BYTE1;
      8'h02: data = flash_cmd_pkg::SIG_BYTE2;
      8'h03: data = flash_cmd_pkg::SIG_BYTE3;
      8'h04: data = flash_cmd_pkg::REV_MINOR;
      8'h05: data = flash_cmd_pkg::REV_MAJOR;
      8'h06: data = flash_cmd_pkg::HEADER_COUNT;
      8'h08: data = flash_cmd_pkg::HDR0_ID;
      8'h09: data = flash_cmd_pkg::TABLE_REV_MINOR;
      8'h0A: data = flash_cmd_pkg::TABLE_REV_MAJOR;
      8'h0B: data = flash_cmd_pkg::HDR0_LENGTH;
      8'h0C: data = flash_cmd_pkg::HDR0_POINTER[7:0];
      8'h0D: data = flash_cmd_pkg::HDR0_POINTER[15:8];
      8'h0E: data = flash_cmd_pkg::HDR0_POINTER[23:16];
      8'h10: data = MAKER_ID;
      8'h11: data = flash_cmd_pkg::TABLE_REV_MINOR;
      8'h12: data = flash_cmd_pkg::TABLE_REV_MAJOR;
      8'h13: data = flash_cmd_pkg::HDR1_LENGTH;
      8'h14: data = flash_cmd_pkg::HDR1_POINTER[7:0];
      8'h15: data = flash_cmd_pkg::HDR1_POINTER[15:8];
      8'h16: data = flash_cmd_pkg::HDR1_POINTER[23:16];
      default: data = flash_cmd_pkg::UNUSED_BYTE;
    endcase
  end
endmodule : header_rom

// ===== logic/flash_cmd_core.sv
`timescale 1ns/1ps
module flash_cmd_core #(
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210,
  // Arbitrary neutral maker code.
  parameter logic [7:0] MAKER_ID = 8'hA5
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial link pins.
  input wire logic csN,
  input wire logic sclk,
  input wire logic dataIn,
  input wire logic [2:0] upperDataIn,
  output logic dataOut,
  output logic dataOutEn,
  // Device status.
  input wire logic opBusy,
  output logic resetArmed,
  output logic softReset,
  output logic opAbort,
  output logic standby
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_OPCODE = 5'b00010,
    ST_HEADER = 5'b00100,
    ST_OUTPUT = 5'b01000,
    ST_SKIP = 5'b10000
  } state_e;

  flash_cmd_pkg::link_in_s link;
  logic [2:0] synced;
  state_e state_r, state_nxt;
  logic [8:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] opcode_r, opcode_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] outByte_r, outByte_nxt;
  logic [6:0] uidIdx_r, uidIdx_nxt;
  logic armed_r, armed_nxt;
  logic sclkPrev_r;
  logic dOut_r, dOut_nxt;
  logic dOutEn_r, dOutEn_nxt;
  flash_cmd_pkg::reset_evt_s evt_r, evt_nxt;
  logic [7:0] romData;
  logic rise;
  logic fall;
  logic frameEnd;
  logic [7:0] rxByte;
  logic wholeByte;
  logic standby_r, standby_nxt;

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(flash_cmd_pkg::SYNC_RESET)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn({csN, sclk, dataIn}),
    .pinOut(synced)
  );

  header_rom #(
    .MAKER_ID(MAKER_ID)
  ) u_rom (
    .addr(addr_r),
    .data(romData)
  );

  assign link = synced;
  assign rise = link.clk && !sclkPrev_r;
  assign fall = !link.clk && sclkPrev_r;
  assign frameEnd = link.selN && (state_r != ST_IDLE);
  assign rxByte = {shift_r[6:0], link.din};

  function automatic logic [8:0] header_bits(input logic [7:0] op);
    case (op)
      flash_cmd_pkg::OP_UID_READ: header_bits = 9'(flash_cmd_pkg::UID_DUMMY_BYTES * 8);
      flash_cmd_pkg::OP_TABLE_READ:
        header_bits = 9'((flash_cmd_pkg::TABLE_ADDR_BYTES + flash_cmd_pkg::TABLE_DUMMY_BYTES) * 8);
      default: header_bits = 9'h000;
    endcase
  endfunction : header_bits

  always_comb begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    opcode_nxt = opcode_r;
    addr_nxt = addr_r;
    outByte_nxt = outByte_r;
    uidIdx_nxt = uidIdx_r;
    dOut_nxt = dOut_r;
    dOutEn_nxt = dOutEn_r;
    case (state_r)
      ST_IDLE: begin
        if (!link.selN) begin
          state_nxt = ST_OPCODE;
          bitCnt_nxt = flash_cmd_pkg::COUNT_RESET;
        end
      end
      ST_OPCODE: begin
        if (rise) begin
          shift_nxt = rxByte;
          bitCnt_nxt = bitCnt_r + 9'h001;
          if (bitCnt_r == 9'(flash_cmd_pkg::OPCODE_BITS - 1)) begin
            opcode_nxt = rxByte;
            bitCnt_nxt = flash_cmd_pkg::COUNT_RESET;
            if (rxByte == flash_cmd_pkg::OP_UID_READ || rxByte == flash_cmd_pkg::OP_TABLE_READ) begin
              state_nxt = ST_HEADER;
            end else begin
              state_nxt = ST_SKIP;
            end
          end
        end
      end
      ST_HEADER: begin
        if (rise) begin
          shift_nxt = rxByte;
          bitCnt_nxt = bitCnt_r + 9'h001;
          // Only the low address byte matters; the header area is 24 bytes.
          if (bitCnt_r == 9'h017) begin
            addr_nxt = rxByte;
          end
          if (bitCnt_r == header_bits(opcode_r) - 9'h001) begin
            state_nxt = ST_OUTPUT;
            bitCnt_nxt = flash_cmd_pkg::COUNT_RESET;
            uidIdx_nxt = 7'h7F;
            outByte_nxt = romData;
          end
        end
      end
      ST_OUTPUT: begin
        if (fall) begin
          dOutEn_nxt = 1'b1;
          bitCnt_nxt = bitCnt_r + 9'h001;
          if (opcode_r == flash_cmd_pkg::OP_UID_READ) begin
            dOut_nxt = UNIQUE_ID[uidIdx_r];
            uidIdx_nxt = uidIdx_r - 7'h01;
            if (bitCnt_r == 9'(flash_cmd_pkg::UID_BITS - 1)) begin
              state_nxt = ST_SKIP;
            end
          end else begin
            dOut_nxt = outByte_r[3'(7 - bitCnt_r[2:0])];
            if (bitCnt_r[2:0] == 3'h7) begin
              addr_nxt = addr_r + 8'h01;
            end
            // Reloading on every byte boundary keeps long reads right after the count wraps.
            if (bitCnt_r[2:0] == 3'h0) begin
              outByte_nxt = romData;
              dOut_nxt = romData[7];
            end
          end
        end
      end
      ST_SKIP: begin
        if (rise) begin
          bitCnt_nxt = bitCnt_r + 9'h001;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (frameEnd) begin
      state_nxt = ST_IDLE;
      dOutEn_nxt = 1'b0;
      dOut_nxt = 1'b0;
    end
  end

  // An opcode counts only when eight clocks, plus any multiple of 512 as the 9-bit count wraps, came before the deselect.
  assign wholeByte = (state_r == ST_SKIP) && (bitCnt_r == flash_cmd_pkg::COUNT_RESET);

  always_comb begin
    armed_nxt = armed_r;
    evt_nxt = '0;
    standby_nxt = (state_nxt == ST_IDLE);
    if (frameEnd) begin
      if (wholeByte) begin
        if (opcode_r == flash_cmd_pkg::OP_RESET_ARM) begin
          armed_nxt = 1'b1;
        end else if (opcode_r == flash_cmd_pkg::OP_RESET_EXEC && armed_r) begin
          evt_nxt.resetPulse = 1'b1;
          evt_nxt.abortOp = opBusy;
          armed_nxt = 1'b0;
        end else begin
          armed_nxt = 1'b0;
        end
      end else begin
        armed_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      bitCnt_r <= flash_cmd_pkg::COUNT_RESET;
      shift_r <= flash_cmd_pkg::BYTE_RESET;
      opcode_r <= flash_cmd_pkg::BYTE_RESET;
      addr_r <= flash_cmd_pkg::BYTE_RESET;
      outByte_r <= flash_cmd_pkg::BYTE_RESET;
      uidIdx_r <= 7'h7F;
      sclkPrev_r <= flash_cmd_pkg::SYNC_RESET[1];
      dOut_r <= 1'b0;
      dOutEn_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      opcode_r <= opcode_nxt;
      addr_r <= addr_nxt;
      outByte_r <= outByte_nxt;
      uidIdx_r <= uidIdx_nxt;
      sclkPrev_r <= link.clk;
      dOut_r <= dOut_nxt;
      dOutEn_r <= dOutEn_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      armed_r <= 1'b0;
      evt_r <= '0;
      standby_r <= 1'b1;
    end else begin
      armed_r <= armed_nxt;
      evt_r <= evt_nxt;
      standby_r <= standby_nxt;
    end
  end

  assign softReset = evt_r.resetPulse;
  assign opAbort = evt_r.abortOp;
  assign resetArmed = armed_r;
  assign dataOut = dOut_r;
  assign dataOutEn = dOutEn_r;
  // Standby is high whenever no frame is in progress.
  assign standby = standby_r;
endmodule : flash_cmd_core

// ===== test/flash_cmd_core_assertions.sv
`timescale 1ns/1ps
module flash_cmd_core_assertions (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Watched ports.
  input wire logic csN,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic opBusy,
  input wire logic resetArmed,
  input wire logic softReset,
  input wire logic opAbort,
  input wire logic standby
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_abort_with_reset: assert property (opAbort |-> softReset)
    else $error("abort without reset");
  a_abort_needs_busy: assert property (opAbort |-> $past(opBusy))
    else $error("abort while idle");
  a_reset_one_pulse: assert property (softReset |=> !softReset)
    else $error("reset pulse too long");
  a_reset_needs_arm: assert property (softReset |-> $past(resetArmed))
    else $error("reset without arm");
  a_reset_disarms: assert property (softReset |=> !resetArmed)
    else $error("arm kept after reset");
  // Six cycles cover the pin synchroniser and the output register.
  a_idle_no_drive: assert property (csN [*6] |-> !dataOutEn)
    else $error("driving while deselected");
  a_idle_out_low: assert property (!dataOutEn |-> !dataOut)
    else $error("output high while released");
  a_idle_standby: assert property (csN [*6] |-> standby)
    else $error("no standby when idle");
  a_busy_no_standby: assert property (!csN [*6] |-> !standby)
    else $error("standby inside frame");
  a_arm_holds: assert property (!csN [*6] |=> $stable(resetArmed))
    else $error("arm changed inside frame");
endmodule : flash_cmd_core_assertions

bind flash_cmd_core flash_cmd_core_assertions u_chk (.sys_clk(sys_clk), .resetn(resetn), .csN(csN),
  .dataOut(dataOut), .dataOutEn(dataOutEn), .opBusy(opBusy), .resetArmed(resetArmed),
  .softReset(softReset), .opAbort(opAbort), .standby(standby));

// ===== test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Clock and device output.
  input wire logic sys_clk,
  input wire logic dataOut,
  // Link to the device.
  output flash_cmd_pkg::link_in_s link
);
  initial begin
    link = '{selN: 1'b1, clk: 1'b0, din: 1'b0};
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_clk

  task automatic frame(input int nBits, input logic [255:0] tx, output logic [255:0] rx);
    rx = '0;
    wait_clk(1);
    link.selN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      link.din = tx[255-i];
      wait_clk(6);
      link.clk = 1'b1;
      rx = {rx[254:0], dataOut};
      wait_clk(6);
      link.clk = 1'b0;
    end
    wait_clk(6);
    link.selN = 1'b1;
    repeat (8) begin
      wait_clk(1);
      link.din = ~link.din;
    end
  endtask : frame
endmodule : spi_host_model

// ===== test/spi_flash_reset_uid_sfdp_tb_top.sv
`timescale 1ns/1ps
module spi_flash_reset_uid_sfdp_tb_top;
  localparam logic [127:0] UID = 128'hC3A50F1E2D3C4B5A69788796A5B4C3D2;
  // Arbitrary maker code, also placed at table byte 16.
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [191:0] TABLE = 192'h53464450000101FF00000109300000FF3C000103600000FF;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic opBusy = 1'b0;
  logic [2:0] upperDataIn = 3'h0;
  logic dataOut, dataOutEn, resetArmed, softReset, opAbort, standby;
  logic [255:0] rx;
  flash_cmd_pkg::link_in_s link;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int resets = 0;
  int aborts = 0;

  flash_cmd_core #(.UNIQUE_ID(UID), .MAKER_ID(MAKER)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
    .csN(link.selN), .sclk(link.clk), .dataIn(link.din), .upperDataIn(upperDataIn), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .opBusy(opBusy), .resetArmed(resetArmed), .softReset(softReset),
    .opAbort(opAbort), .standby(standby));
  spi_host_model u_host (.sys_clk(sys_clk), .dataOut(dataOut), .link(link));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (softReset === 1'b1) resets++;
    if (opAbort === 1'b1) aborts++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic bad(input string what);
    errors++;
    $display("BAD %0t %s", $time, what);
  endtask : bad
  task automatic chk1(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) bad(what);
  endtask : chk1
  task automatic chkv(input logic [191:0] got, input logic [191:0] exp, input string what);
    checks++;
    if (got !== exp) bad(what);
  endtask : chkv
  task automatic chkn(input int got, input int exp, input string what);
    checks++;
    if (got != exp) bad(what);
  endtask : chkn

  task automatic arm_exec(input logic busy, input int resetExp, input int abortExp);
    int r0;
    int a0;
    r0 = resets;
    a0 = aborts;
    opBusy = busy;
    upperDataIn = 3'h7;
    u_host.frame(8, {flash_cmd_pkg::OP_RESET_ARM, 248'h0}, rx);
    chk1(resetArmed, 1'b1, "not armed");
    upperDataIn = 3'h2;
    u_host.frame(8, {flash_cmd_pkg::OP_RESET_EXEC, 248'h0}, rx);
    chkn(resets - r0, resetExp, "reset count");
    chkn(aborts - a0, abortExp, "abort count");
    chk1(resetArmed, 1'b0, "still armed");
    chk1(standby, 1'b1, "no standby");
    opBusy = 1'b0;
  endtask : arm_exec

  task automatic test_cancel();
    logic [7:0] ops [3] = '{flash_cmd_pkg::OP_NO_OPERATION, flash_cmd_pkg::OP_UID_READ, 8'hA7};
    int r0;
    foreach (ops[i]) begin
      r0 = resets;
      u_host.frame(8, {flash_cmd_pkg::OP_RESET_ARM, 248'h0}, rx);
      u_host.frame(8, {ops[i], 248'h0}, rx);
      chk1(resetArmed, 1'b0, "arm survived");
      u_host.frame(8, {flash_cmd_pkg::OP_RESET_EXEC, 248'h0}, rx);
      chkn(resets - r0, 0, "stale reset");
    end
    r0 = resets;
    u_host.frame(8, {flash_cmd_pkg::OP_RESET_ARM, 248'h0}, rx);
    u_host.frame(16, {flash_cmd_pkg::OP_RESET_EXEC, flash_cmd_pkg::OP_RESET_EXEC, 240'h0}, rx);
    chkn(resets - r0, 0, "long frame reset");
    chk1(resetArmed, 1'b0, "long frame armed");
    $display("test_cancel done");
  endtask : test_cancel

  task automatic test_hw_reset();
    int r0;
    r0 = resets;
    u_host.frame(8, {flash_cmd_pkg::OP_RESET_ARM, 248'h0}, rx);
    chk1(resetArmed, 1'b1, "arm before reset");
    resetn = 1'b0;
    u_host.wait_clk(1);
    chk1(resetArmed, 1'b0, "arm kept by reset");
    chk1(standby, 1'b1, "reset not standby");
    resetn = 1'b1;
    u_host.frame(8, {flash_cmd_pkg::OP_RESET_EXEC, 248'h0}, rx);
    chkn(resets - r0, 0, "reset after power-up state");
    chk1(dataOutEn, 1'b0, "driving after reset");
    $display("test_hw_reset done");
  endtask : test_hw_reset

  task automatic test_uid();
    u_host.frame(168, {flash_cmd_pkg::OP_UID_READ, 248'h0}, rx);
    chkv({64'h0, rx[127:0]}, {64'h0, UID}, "unique id");
    $display("test_uid done");
  endtask : test_uid

  task automatic test_table();
    u_host.frame(232, {flash_cmd_pkg::OP_TABLE_READ, 248'h0}, rx);
    chkv(rx[191:0], TABLE, "header area");
    u_host.frame(44, {flash_cmd_pkg::OP_TABLE_READ, 24'h000010, 224'h0}, rx);
    chkv({188'h0, rx[3:0]}, {188'h0, MAKER[7:4]}, "cut read");
    chk1(dataOutEn, 1'b0, "still driving");
    $display("test_table done");
  endtask : test_table

  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    test_uid();
    arm_exec(1'b0, 1, 0);
    $display("test_reset done");
    arm_exec(1'b1, 1, 1);
    $display("test_abort done");
    test_cancel();
    test_hw_reset();
    test_table();
    test_uid();
    complete_run();
  end
endmodule : spi_flash_reset_uid_sfdp_tb_top
